// ===== rtl/bank1_pad_clock_config.sv
// Bank-one clock, power-mode, pad and option register bank
//
// The implementer's own choices: the plain strobed port and the register addresses.
`include "bank1_params.svh"
// Operation
// RULE_01 - Bit 6 picks timer clock source
// RULE_02 - Bit 5 picks CPU clock source
// RULE_03 - CPU on sub clock stops main
// RULE_04 - Power-down: bit 4 chooses sleep/idle
// RULE_05 - Bits 3..0 choose pin sink strength
// RULE_06 - Port-5 pull-down register, active-low bits
// RULE_07 - Pull-down bits reset to one
// RULE_08 - Port-7 pull-down register, bits 4..0
// RULE_09 - Port-6 open-drain, active-low bits
// RULE_10 - Port-7 open-drain, bits 4..0
// RULE_11 - Pull-high: port5 7..4, port6 3..0
// RULE_12 - Port-7 pull-high, low five bits
// RULE_13 - Option type field picks package
// RULE_14 - Option field picks low-voltage reset
// RULE_15 - Option field picks RC frequency
// RULE_16 - 0x10..0x3F general-purpose registers
// RULE_17 - Accumulator not in register file
// RULE_18 - Unused bits ignore writes, read zero
// RULE_19 - Writes take effect next instruction
module bank1_pad_clock_config (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [5:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [7:0] rd_data_out,
    // Power-down instruction and wake event from the core
    input wire logic power_down_instr_in,
    input wire logic wake_in,
    // Clock steering
    output logic timer_clk_select_out,
    output logic cpu_clk_select_out,
    output logic main_osc_en_out,
    output logic sleep_mode_out,
    output logic idle_mode_out,
    // Pad controls
    output logic [3:0] sink_strength_sel_out,
    output logic [7:0] pulldown_dis_p5_out,
    output logic [4:0] pulldown_dis_p7_out,
    output logic [7:0] opendrain_dis_p6_out,
    output logic [4:0] opendrain_dis_p7_out,
    output logic [3:0] pullhigh_dis_p5_out,
    output logic [3:0] pullhigh_dis_p6_out,
    output logic [4:0] pullhigh_dis_p7_out,
    // Option fields
    output logic [2:0] package_sel_out,
    output logic [1:0] lowv_reset_sel_out,
    output logic [1:0] rc_freq_sel_out
);
    typedef struct packed {
        logic [7:0] rd_data;
        bank1_pkg::power_state_t pwr;
        logic timer_clk;
        logic cpu_clk;
        logic main_en;
        logic [3:0] sink;
        logic [7:0] pd5;
        logic [4:0] pd7;
        logic [7:0] od6;
        logic [4:0] od7;
        logic [7:0] ph56;
        logic [4:0] ph7;
        bank1_pkg::package_sel_t pkg;
        logic [1:0] lvr;
        logic [1:0] rcm;
    } top_state_t;

    top_state_t state;
    top_state_t next_state;

    logic [7:0] r_clk_sink;
    logic [7:0] r_p5_pd;
    logic [7:0] r_p7_pd;
    logic [7:0] r_p6_od;
    logic [7:0] r_p7_od;
    logic [7:0] r_p56_ph;
    logic [7:0] r_p7_ph;
    logic [7:0] r_option;
    logic [7:0] gp_rd;
    logic [5:0] gp_index;
    logic gp_hit;
    logic we_clk_sink;
    logic we_p5_pd;
    logic we_p7_pd;
    logic we_p6_od;
    logic we_p7_od;
    logic we_p56_ph;
    logic we_p7_ph;
    logic we_option;

    // RULE_19 write cycle decode
    assign we_clk_sink = wr_en_in && (addr_in == `ADDR_CLK_SINK);
    assign we_p5_pd = wr_en_in && (addr_in == `ADDR_P5_PD);
    assign we_p7_pd = wr_en_in && (addr_in == `ADDR_P7_PD);
    assign we_p6_od = wr_en_in && (addr_in == `ADDR_P6_OD);
    assign we_p7_od = wr_en_in && (addr_in == `ADDR_P7_OD);
    assign we_p56_ph = wr_en_in && (addr_in == `ADDR_P56_PH);
    assign we_p7_ph = wr_en_in && (addr_in == `ADDR_P7_PH);
    assign we_option = wr_en_in && (addr_in == `ADDR_OPTION);
    // RULE_16 general-purpose window
    assign gp_hit = (addr_in >= `GP_FIRST) && (addr_in <= `GP_LAST);
    assign gp_index = addr_in - `GP_FIRST;

    config_reg8 #(
        .RESET_VALUE(`RST_CLK_SINK),
        .WRITE_MASK(`MASK_CLK_SINK)
    ) u_clk_sink (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(we_clk_sink),
        .wr_data_in(wr_data_in),
        .value_out(r_clk_sink)
    );

    // RULE_06 port-5 pull-down storage
    // RULE_07 reset to all ones
    config_reg8 #(
        .RESET_VALUE(`RST_ALL_ONES),
        .WRITE_MASK(`RST_ALL_ONES)
    ) u_p5_pd (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(we_p5_pd),
        .wr_data_in(wr_data_in),
        .value_out(r_p5_pd)
    );

    // RULE_08 port-7 pull-down storage
    config_reg8 #(
        .RESET_VALUE(`RST_P7),
        .WRITE_MASK(`MASK_P7)
    ) u_p7_pd (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(we_p7_pd),
        .wr_data_in(wr_data_in),
        .value_out(r_p7_pd)
    );

    // RULE_09 port-6 open-drain storage
    config_reg8 #(
        .RESET_VALUE(`RST_ALL_ONES),
        .WRITE_MASK(`RST_ALL_ONES)
    ) u_p6_od (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(we_p6_od),
        .wr_data_in(wr_data_in),
        .value_out(r_p6_od)
    );

    // RULE_10 port-7 open-drain storage
    config_reg8 #(
        .RESET_VALUE(`RST_P7),
        .WRITE_MASK(`MASK_P7)
    ) u_p7_od (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(we_p7_od),
        .wr_data_in(wr_data_in),
        .value_out(r_p7_od)
    );

    // RULE_11 pull-high for ports 5 and 6
    config_reg8 #(
        .RESET_VALUE(`RST_ALL_ONES),
        .WRITE_MASK(`RST_ALL_ONES)
    ) u_p56_ph (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(we_p56_ph),
        .wr_data_in(wr_data_in),
        .value_out(r_p56_ph)
    );

    // RULE_12 port-7 pull-high storage
    config_reg8 #(
        .RESET_VALUE(`RST_P7),
        .WRITE_MASK(`MASK_P7)
    ) u_p7_ph (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(we_p7_ph),
        .wr_data_in(wr_data_in),
        .value_out(r_p7_ph)
    );

    // RULE_13 option defaults: large package, 4 MHz
    config_reg8 #(
        .RESET_VALUE(`RST_OPTION),
        .WRITE_MASK(`MASK_OPTION)
    ) u_option (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(we_option),
        .wr_data_in(wr_data_in),
        .value_out(r_option)
    );

    gp_file u_gp (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(wr_en_in && gp_hit),
        .index_in(gp_index),
        .wr_data_in(wr_data_in),
        .rd_data_out(gp_rd)
    );

    always_comb
    begin
        next_state = state;
        // RULE_17 no accumulator address
        if (!rd_en_in)
        begin
            next_state.rd_data = 8'h00;
        end
        else if (addr_in == `ADDR_CLK_SINK)
        begin
            next_state.rd_data = r_clk_sink;
        end
        else if (addr_in == `ADDR_P5_PD)
        begin
            next_state.rd_data = r_p5_pd;
        end
        else if (addr_in == `ADDR_P7_PD)
        begin
            next_state.rd_data = r_p7_pd;
        end
        else if (addr_in == `ADDR_P6_OD)
        begin
            next_state.rd_data = r_p6_od;
        end
        else if (addr_in == `ADDR_P7_OD)
        begin
            next_state.rd_data = r_p7_od;
        end
        else if (addr_in == `ADDR_P56_PH)
        begin
            next_state.rd_data = r_p56_ph;
        end
        else if (addr_in == `ADDR_P7_PH)
        begin
            next_state.rd_data = r_p7_ph;
        end
        else if (addr_in == `ADDR_OPTION)
        begin
            next_state.rd_data = r_option;
        end
        else if (gp_hit)
        begin
            next_state.rd_data = gp_rd;
        end
        else
        begin
            // Unmapped reads return zero
            next_state.rd_data = 8'h00;
        end

        // RULE_01 timer clock source
        next_state.timer_clk = r_clk_sink[`BIT_TIMER_CLK];
        // RULE_02 CPU clock source
        next_state.cpu_clk = r_clk_sink[`BIT_CPU_CLK];
        // RULE_03 main stops on sub clock
        next_state.main_en = r_clk_sink[`BIT_CPU_CLK];
        // RULE_05 sink strength per pin
        next_state.sink = r_clk_sink[3:0];
        next_state.pd5 = r_p5_pd;
        next_state.pd7 = r_p7_pd[4:0];
        next_state.od6 = r_p6_od;
        next_state.od7 = r_p7_od[4:0];
        next_state.ph56 = r_p56_ph;
        next_state.ph7 = r_p7_ph[4:0];

        // RULE_13 package decode, 00 aliases largest
        case (r_option[`TYPE_HI:`TYPE_LO])
            2'h2: next_state.pkg = bank1_pkg::PKG_MIDDLE;
            2'h1: next_state.pkg = bank1_pkg::PKG_SMALL;
            default: next_state.pkg = bank1_pkg::PKG_LARGE;
        endcase
        // RULE_14 reset threshold code
        next_state.lvr = r_option[`LVR_HI:`LVR_LO];
        // RULE_15 RC frequency code
        next_state.rcm = r_option[`RCM_HI:`RCM_LO];

        // RULE_04 sleep or idle on power-down
        case (state.pwr)
            bank1_pkg::PWR_RUN:
            begin
                if (power_down_instr_in)
                begin
                    if (r_clk_sink[`BIT_IDLE])
                    begin
                        next_state.pwr = bank1_pkg::PWR_IDLE;
                    end
                    else
                    begin
                        next_state.pwr = bank1_pkg::PWR_SLEEP;
                    end
                end
            end
            bank1_pkg::PWR_SLEEP,
            bank1_pkg::PWR_IDLE:
            begin
                if (wake_in)
                begin
                    next_state.pwr = bank1_pkg::PWR_RUN;
                end
            end
            default:
            begin
                next_state.pwr = bank1_pkg::PWR_RUN;
            end
        endcase
    end

    // Outputs lag the register by one edge so each is a flop
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            state.rd_data <= 8'h00;
            state.pwr <= bank1_pkg::PWR_RUN;
            state.timer_clk <= 1'b0;
            state.cpu_clk <= 1'b0;
            state.main_en <= 1'b0;
            state.sink <= 4'h0;
            state.pd5 <= `RST_ALL_ONES;
            state.pd7 <= 5'h1F;
            state.od6 <= `RST_ALL_ONES;
            state.od7 <= 5'h1F;
            state.ph56 <= `RST_ALL_ONES;
            state.ph7 <= 5'h1F;
            state.pkg <= bank1_pkg::PKG_LARGE;
            state.lvr <= 2'h3;
            state.rcm <= 2'h3;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign rd_data_out = state.rd_data;
    assign timer_clk_select_out = state.timer_clk;
    assign cpu_clk_select_out = state.cpu_clk;
    assign main_osc_en_out = state.main_en;
    assign sleep_mode_out = (state.pwr == bank1_pkg::PWR_SLEEP);
    assign idle_mode_out = (state.pwr == bank1_pkg::PWR_IDLE);
    assign sink_strength_sel_out = state.sink;
    assign pulldown_dis_p5_out = state.pd5;
    assign pulldown_dis_p7_out = state.pd7;
    assign opendrain_dis_p6_out = state.od6;
    assign opendrain_dis_p7_out = state.od7;
    assign pullhigh_dis_p5_out = state.ph56[7:4];
    assign pullhigh_dis_p6_out = state.ph56[3:0];
    assign pullhigh_dis_p7_out = state.ph7;
    assign package_sel_out = state.pkg;
    assign lowv_reset_sel_out = state.lvr;
    assign rc_freq_sel_out = state.rcm;
endmodule

// ===== rtl/bank1_params.svh
// Constants for the bank-one pad, clock and option register bank
`ifndef BANK1_PARAMS_SVH
`define BANK1_PARAMS_SVH

`define ADDR_W 6
`define DATA_W 8
`define ADDR_CLK_SINK 6'h07
`define ADDR_P5_PD 6'h08
`define ADDR_P7_PD 6'h09
`define ADDR_P6_OD 6'h0A
`define ADDR_P7_OD 6'h0B
`define ADDR_P56_PH 6'h0C
`define ADDR_P7_PH 6'h0D
`define ADDR_OPTION 6'h0E
`define GP_FIRST 6'h10
`define GP_LAST 6'h3F
`define GP_DEPTH 48

`define MASK_CLK_SINK 8'h7F
`define MASK_P7 8'h1F
`define MASK_OPTION 8'hFC
`define RST_CLK_SINK 8'h00
`define RST_ALL_ONES 8'hFF
`define RST_P7 8'h1F
`define RST_OPTION 8'hFC

`define BIT_TIMER_CLK 6
`define BIT_CPU_CLK 5
`define BIT_IDLE 4
`define TYPE_HI 7
`define TYPE_LO 6
`define LVR_HI 5
`define LVR_LO 4
`define RCM_HI 3
`define RCM_LO 2

`endif

// ===== rtl/bank1_pkg.sv
// Types shared by the bank-one register bank
package bank1_pkg;
    typedef enum logic [2:0] {
        PWR_RUN = 3'h1,
        PWR_SLEEP = 3'h2,
        PWR_IDLE = 3'h4
    } power_state_t;

    typedef enum logic [2:0] {
        PKG_LARGE = 3'h1,
        PKG_MIDDLE = 3'h2,
        PKG_SMALL = 3'h4
    } package_sel_t;
endpackage

// ===== rtl/config_reg8.sv
// One masked byte-wide configuration register
`include "bank1_params.svh"
module config_reg8 #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK = 8'hFF
)(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Write port
    input wire logic wr_en_in,
    input wire logic [7:0] wr_data_in,
    // Stored value
    output logic [7:0] value_out
);
    typedef struct packed {
        logic [7:0] value;
    } cfg_state_t;

    cfg_state_t state;
    cfg_state_t next_state;

    always_comb
    begin
        next_state = state;
        // RULE_18 unused bits zero
        if (wr_en_in)
        begin
            next_state.value = wr_data_in & WRITE_MASK;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            state.value <= RESET_VALUE;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign value_out = state.value;
endmodule

// ===== rtl/gp_file.sv
// General-purpose file registers at 0x10 to 0x3F
`include "bank1_params.svh"
module gp_file (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Access port, index already relative to the first location
    input wire logic wr_en_in,
    input wire logic [5:0] index_in,
    input wire logic [7:0] wr_data_in,
    output logic [7:0] rd_data_out
);
    typedef struct packed {
        logic [`GP_DEPTH-1:0][7:0] mem;
    } gp_state_t;

    gp_state_t state;
    gp_state_t next_state;

    always_comb
    begin
        next_state = state;
        // RULE_16 plain storage
        if (wr_en_in)
        begin
            next_state.mem[index_in] = wr_data_in;
        end
    end

    // No reset: file contents are undefined at power-up
    always_ff @(posedge mclk_in)
    begin
        state <= next_state;
    end

    assign rd_data_out = state.mem[index_in];
endmodule

// ===== sim/bank1_pad_clock_config_assertions.sv
// Concurrent checks on the bank-one register bank ports
`include "bank1_params.svh"
module bank1_pad_clock_config_assertions (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [5:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [7:0] rd_data_out,
    // Power, clock steering and port-7 pull-down
    input wire logic power_down_instr_in,
    input wire logic wake_in,
    input wire logic timer_clk_select_out,
    input wire logic cpu_clk_select_out,
    input wire logic main_osc_en_out,
    input wire logic sleep_mode_out,
    input wire logic idle_mode_out,
    input wire logic [4:0] pulldown_dis_p7_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);

    logic idle_bit;

    // Mirror of the idle enable bit, updated like the register
    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
            idle_bit <= 1'b0;
        else if (wr_en_in && addr_in == `ADDR_CLK_SINK)
            idle_bit <= wr_data_in[`BIT_IDLE];
    end

    sequence clk_wr;
        wr_en_in && addr_in == `ADDR_CLK_SINK;
    endsequence

    sequence run_pd;
        !sleep_mode_out && !idle_mode_out && power_down_instr_in && !wake_in;
    endsequence

    timer_sel_a:
        assert property (clk_wr |-> ##2 timer_clk_select_out ==
            $past(wr_data_in[6], 2)) else $error("timer clock select wrong");
    cpu_sel_a:
        assert property (clk_wr |-> ##2 cpu_clk_select_out ==
            $past(wr_data_in[5], 2)) else $error("cpu clock select wrong");
    osc_stop_a:
        assert property (clk_wr |-> ##2 main_osc_en_out ==
            $past(wr_data_in[5], 2)) else $error("main osc enable wrong");
    sleep_entry_a:
        assert property (run_pd |=> sleep_mode_out == !$past(idle_bit) &&
            idle_mode_out == $past(idle_bit)) else $error("power-down mode");
    wake_run_a:
        assert property (wake_in && !power_down_instr_in |=>
            !sleep_mode_out && !idle_mode_out) else $error("no return to run");
    mode_hold_a:
        assert property ((sleep_mode_out || idle_mode_out) && !wake_in |=>
            $stable({sleep_mode_out, idle_mode_out}))
            else $error("power-down mode left without wake");
    rd_quiet_a:
        assert property (!rd_en_in |=> rd_data_out == 8'h00)
            else $error("read data not zero outside read");
    unmapped_rd_a:
        assert property (rd_en_in && (addr_in < 6'h07 || addr_in == 6'h0F)
            |=> rd_data_out == 8'h00) else $error("unmapped read not zero");
    p7_pd_a:
        assert property (wr_en_in && addr_in == `ADDR_P7_PD |-> ##2
            pulldown_dis_p7_out == $past(wr_data_in[4:0], 2))
            else $error("port-7 pull-down output wrong");
endmodule

bind bank1_pad_clock_config bank1_pad_clock_config_assertions i_chk (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .addr_in(addr_in),
    .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out),
    .power_down_instr_in(power_down_instr_in),
    .wake_in(wake_in),
    .timer_clk_select_out(timer_clk_select_out),
    .cpu_clk_select_out(cpu_clk_select_out),
    .main_osc_en_out(main_osc_en_out),
    .sleep_mode_out(sleep_mode_out),
    .idle_mode_out(idle_mode_out),
    .pulldown_dis_p7_out(pulldown_dis_p7_out)
);

// ===== sim/bank1_pad_clock_config_tb.sv
// Self-checking bench for the bank-one register bank
`include "bank1_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module bank1_pad_clock_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in, rst_n_in, wr_en_in, rd_en_in;
    logic power_down_instr_in, wake_in;
    logic [5:0] addr_in;
    logic [7:0] wr_data_in, rd_data_out;
    logic timer_clk_select_out, cpu_clk_select_out, main_osc_en_out;
    logic sleep_mode_out, idle_mode_out;
    logic [3:0] sink_strength_sel_out, pullhigh_dis_p5_out;
    logic [3:0] pullhigh_dis_p6_out;
    logic [7:0] pulldown_dis_p5_out, opendrain_dis_p6_out;
    logic [4:0] pulldown_dis_p7_out, opendrain_dis_p7_out;
    logic [4:0] pullhigh_dis_p7_out;
    logic [2:0] package_sel_out;
    logic [1:0] lowv_reset_sel_out, rc_freq_sel_out;
    int n_errors = 0;
    int check_count = 0;
    logic [7:0] rnd = 8'h14;
    // Expected contents of every address
    logic [7:0] sh [64];

    bank1_pad_clock_config i_bank1_pad_clock_config (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .addr_in(addr_in),
        .wr_data_in(wr_data_in),
        .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in),
        .rd_data_out(rd_data_out),
        .power_down_instr_in(power_down_instr_in),
        .wake_in(wake_in),
        .timer_clk_select_out(timer_clk_select_out),
        .cpu_clk_select_out(cpu_clk_select_out),
        .main_osc_en_out(main_osc_en_out),
        .sleep_mode_out(sleep_mode_out),
        .idle_mode_out(idle_mode_out),
        .sink_strength_sel_out(sink_strength_sel_out),
        .pulldown_dis_p5_out(pulldown_dis_p5_out),
        .pulldown_dis_p7_out(pulldown_dis_p7_out),
        .opendrain_dis_p6_out(opendrain_dis_p6_out),
        .opendrain_dis_p7_out(opendrain_dis_p7_out),
        .pullhigh_dis_p5_out(pullhigh_dis_p5_out),
        .pullhigh_dis_p6_out(pullhigh_dis_p6_out),
        .pullhigh_dis_p7_out(pullhigh_dis_p7_out),
        .package_sel_out(package_sel_out),
        .lowv_reset_sel_out(lowv_reset_sel_out),
        .rc_freq_sel_out(rc_freq_sel_out)
    );

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Writable bits per address; zero means unmapped
    function automatic logic [7:0] wmask(input logic [5:0] a);
        if (a == 6'h07)
            return 8'h7F;
        if (a == 6'h09 || a == 6'h0B || a == 6'h0D)
            return 8'h1F;
        if (a == 6'h0E)
            return 8'hFC;
        if ((a >= 6'h08 && a <= 6'h0C) || a >= 6'h10)
            return 8'hFF;
        return 8'h00;
    endfunction

    function automatic logic [2:0] pkg_of(input logic [1:0] t);
        if (t == 2'b10)
            return bank1_pkg::PKG_MIDDLE;
        if (t == 2'b01)
            return bank1_pkg::PKG_SMALL;
        return bank1_pkg::PKG_LARGE;
    endfunction

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge mclk_in);
        wr_en_in <= 1'b0;
        sh[a] = (sh[a] & ~wmask(a)) | (d & wmask(a));
    endtask

    task automatic rd(input logic [5:0] a);
        @(posedge mclk_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge mclk_in);
        rd_en_in <= 1'b0;
        #1;
        `CHK(rd_data_out, sh[a])
    endtask

    // Pad and clock outputs settle two edges after the write
    task automatic chk_outs;
        logic [7:0] c;
        logic [7:0] o;
        @(posedge mclk_in);
        #1;
        c = sh[7];
        o = sh[14];
        `CHK(timer_clk_select_out, c[6])
        `CHK(cpu_clk_select_out, c[5])
        `CHK(main_osc_en_out, c[5])
        `CHK(sink_strength_sel_out, c[3:0])
        `CHK(pulldown_dis_p5_out, sh[8])
        `CHK(pulldown_dis_p7_out, sh[9][4:0])
        `CHK(opendrain_dis_p6_out, sh[10])
        `CHK(opendrain_dis_p7_out, sh[11][4:0])
        `CHK({pullhigh_dis_p5_out, pullhigh_dis_p6_out}, sh[12])
        `CHK(pullhigh_dis_p7_out, sh[13][4:0])
        `CHK(package_sel_out, pkg_of(o[7:6]))
        `CHK(lowv_reset_sel_out, o[5:4])
        `CHK(rc_freq_sel_out, o[3:2])
    endtask

    task automatic pd(input logic idle);
        wr(`ADDR_CLK_SINK, {sh[7][7:5], idle, sh[7][3:0]});
        @(posedge mclk_in);
        power_down_instr_in <= 1'b1;
        @(posedge mclk_in);
        power_down_instr_in <= 1'b0;
        #1;
        `CHK({sleep_mode_out, idle_mode_out}, {!idle, idle})
        @(posedge mclk_in);
        wake_in <= 1'b1;
        @(posedge mclk_in);
        wake_in <= 1'b0;
        #1;
        `CHK({sleep_mode_out, idle_mode_out}, 2'b00)
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    // Cut a hang short
    initial
    begin
        repeat (50000) @(posedge mclk_in);
        n_errors++;
        end_of_test();
    end

    initial
    begin
        rst_n_in = 1'b0;
        addr_in = 6'h00;
        wr_data_in = 8'h00;
        wr_en_in = 1'b0;
        rd_en_in = 1'b0;
        power_down_instr_in = 1'b0;
        wake_in = 1'b0;
        for (int i = 0; i < 64; i++)
            sh[i] = (i >= 8 && i <= 14) ? wmask(i[5:0]) : 8'h00;
        repeat (10) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        for (int i = 7; i < 15; i++)
            rd(i[5:0]);
        chk_outs();
        $display("test reset values done");
        // GP file is not reset, so fill it before reading
        for (int i = 16; i < 64; i++)
        begin
            rnd = lfsr(rnd);
            wr(i[5:0], rnd);
        end
        for (int n = 0; n < 300; n++)
        begin
            rnd = lfsr(rnd);
            wr(rnd[5:0], lfsr(rnd));
            chk_outs();
            rd(rnd[5:0]);
        end
        $display("test random traffic done");
        // Every option code, with the unused low bits set
        for (int i = 0; i < 4; i++)
        begin
            wr(`ADDR_OPTION, {{3{i[1:0]}}, 2'b11});
            chk_outs();
            rd(`ADDR_OPTION);
        end
        wr(`ADDR_CLK_SINK, 8'hFF);
        rd(`ADDR_CLK_SINK);
        wr(`ADDR_P7_OD, 8'hE0);
        rd(`ADDR_P7_OD);
        rd(6'h0F);
        $display("test option codes done");
        pd(1'b0);
        pd(1'b1);
        $display("test power-down done");
        end_of_test();
    end
endmodule
